// ==== design/dma_act_defines.svh ====
// constants for the dma activation and arbitration block
`ifndef DMA_ACT_DEFINES_SVH
`define DMA_ACT_DEFINES_SVH
`define ADR_CHAN_CTRL 4'h0
`define ADR_MODE 4'h1
`define ADR_SRC_SEL 4'h2
`define ADR_STATUS 4'h3
`define ADR_COUNT0 4'h4
`define ADR_COUNT1 4'h5
`define ADR_COUNT2 4'h6
`define ADR_COUNT3 4'h7
`define START_DELAY 3'd4
`define NUM_CHAN 4
`endif

// ==== design/dma_act_pkg.sv ====
// types for the dma activation and arbitration block
package dma_act_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_BUSREQ = 6'b000010,
        ST_DEAD = 6'b000100,
        ST_READ = 6'b001000,
        ST_WRITE = 6'b010000,
        ST_REL = 6'b100000
    } seq_state_type;
endpackage

// ==== design/ext_transfer_request_n_sync.sv ====
// request pin synchroniser and falling edge finder
`timescale 1ns/1ps
module ext_transfer_request_n_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_n_i,
    output logic level_low_o,
    output logic fall_o
);
    logic s1_ff, s2_ff, s3_ff, low_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end else begin
            s1_ff <= pin_n_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // a level counts only once the two later stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            low_ff <= ~s3_ff;
        end
    end
    assign level_low_o = low_ff;
    assign fall_o = (s2_ff == s3_ff) && ~s3_ff && ~low_ff;
endmodule

// ==== design/dma_act_arb.sv ====
// dma activation, bus cycle sequencing and channel arbitration
`timescale 1ns/1ps
`include "dma_act_defines.svh"
module dma_act_arb
    import dma_act_pkg::*;
#(
    parameter int NCH = `NUM_CHAN
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [5:0] int_flag_i,
    output logic [5:0] int_flag_clr_o,
    output logic [5:0] int_to_cpu_o,
    input wire logic [1:0] ext_transfer_request_n_i,
    output logic [1:0] req_pin_force_in_o,
    output logic [1:0] transfer_end_n_o,
    output logic [1:0] transfer_end_oe_o,
    input wire logic nmi_i,
    input wire logic standby_i,
    input wire logic external_bus_request_n_i,
    input wire logic refresh_req_i,
    output logic bus_req_o,
    input wire logic bus_grant_i,
    output logic bus_read_o,
    output logic bus_write_o,
    input wire logic bus_cycle_done_i,
    output logic [1:0] active_chan_o,
    output logic [NCH-1:0] end_irq_o
);
    // bus_cycle_done_i comes from the bus controller, which applies the
    // same area width and wait states to dma cycles as to cpu ones
    seq_state_type state_ff, nxt_state;
    logic [NCH-1:0] chan_en_ff, end_ie_ff;
    logic [1:0] master_en_ff;
    logic full_mode_ff [2];
    logic block_ff [2];
    logic burst_ff [2];
    logic [NCH-1:0] level_ff;
    logic [1:0] src_kind_ff [NCH];
    logic [2:0] src_int_ff [NCH];
    logic [15:0] count_ff [NCH];
    logic [NCH-1:0] pend_ff;
    logic [1:0] cur_ff;
    logic [2:0] wait_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [1:0] dlow, dfall;
    logic [NCH-1:0] want, halt_c;
    logic [1:0] win;
    logic win_ok, yield_c, last_c;

    // source kinds: 0 none, 1 interrupt, 2 external pin (b chans), 3 auto
    genvar g;
    for (g = 0; g < 2; g++) begin : g_pin
        ext_transfer_request_n_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_n_i(ext_transfer_request_n_i[g]),
            .level_low_o(dlow[g]),
            .fall_o(dfall[g])
        );
    end

    function automatic logic runnable(input int c);
        int p;
        p = c / 2;
        runnable = chan_en_ff[c] && (!full_mode_ff[p] || master_en_ff[p]);
    endfunction

    // register slave: one-cycle ack, unmapped reads return zero
    wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
    // writes land on the edge at which the master sees ack high
    wire wb_wr = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
    wire [3:0] widx = wb_adr_i[5:2];
    wire unit_end = (state_ff == ST_WRITE) && bus_cycle_done_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req;
        end
    end
    assign wb_ack_o = ack_ff;

    // enables; hardware clears win over software writes
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            chan_en_ff <= '0;
            end_ie_ff <= '0;
            master_en_ff <= '0;
            full_mode_ff[0] <= 1'b0;
            full_mode_ff[1] <= 1'b0;
            block_ff[0] <= 1'b0;
            block_ff[1] <= 1'b0;
            burst_ff[0] <= 1'b0;
            burst_ff[1] <= 1'b0;
            level_ff <= '0;
        end else begin
            if (wb_wr && widx == `ADR_CHAN_CTRL) begin
                chan_en_ff <= wb_dat_i[3:0];
                end_ie_ff <= wb_dat_i[7:4];
                master_en_ff <= wb_dat_i[9:8];
            end
            if (wb_wr && widx == `ADR_MODE) begin
                full_mode_ff[0] <= wb_dat_i[0];
                full_mode_ff[1] <= wb_dat_i[1];
                block_ff[0] <= wb_dat_i[2];
                block_ff[1] <= wb_dat_i[3];
                burst_ff[0] <= wb_dat_i[4];
                burst_ff[1] <= wb_dat_i[5];
                level_ff <= wb_dat_i[11:8];
            end
            for (int p = 0; p < 2; p++) begin
                if (nmi_i && full_mode_ff[p]) begin
                    master_en_ff[p] <= 1'b0;
                end
            end
            if (unit_end && count_ff[cur_ff] == 16'h0001) begin
                chan_en_ff[cur_ff] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            for (int c = 0; c < NCH; c++) begin
                src_kind_ff[c] <= 2'd0;
                src_int_ff[c] <= 3'd0;
            end
        end else if (wb_wr && widx == `ADR_SRC_SEL) begin
            for (int c = 0; c < NCH; c++) begin
                src_kind_ff[c] <= wb_dat_i[8*c +: 2];
                src_int_ff[c] <= wb_dat_i[8*c+2 +: 3];
            end
        end
    end

    // unit counters: written by software, decremented per unit
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            for (int c = 0; c < NCH; c++) begin
                count_ff[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wb_wr && widx == `ADR_COUNT0 + 4'(c)) begin
                    count_ff[c] <= wb_dat_i[15:0];
                end else if (unit_end && cur_ff == 2'(c)) begin
                    count_ff[c] <= count_ff[c] - 16'h0001;
                end
            end
        end
    end

    // pending requests per channel
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            want[c] = 1'b0;
            halt_c[c] = !runnable(c);
            case (src_kind_ff[c])
                2'd1: want[c] = int_flag_i[src_int_ff[c]];
                2'd2: begin
                    if (c[0] && !halt_c[c]) begin
                        if (level_ff[c] && !block_ff[c/2]) begin
                            want[c] = dlow[c/2];
                        end else begin
                            want[c] = dfall[c/2];
                        end
                    end
                end
                2'd3: want[c] = full_mode_ff[c/2];
                default: want[c] = 1'b0;
            endcase
        end
    end

    // pin not looked at from request until the read ends
    wire pin_blind = (state_ff == ST_BUSREQ) || (state_ff == ST_DEAD) ||
                     (state_ff == ST_READ && !bus_cycle_done_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            pend_ff <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (halt_c[c]) begin
                    pend_ff[c] <= 1'b0;
                end else if (want[c] &&
                        !(src_kind_ff[c] == 2'd2 && pin_blind &&
                          cur_ff == 2'(c))) begin
                    pend_ff[c] <= 1'b1;
                end else if (unit_end && cur_ff == 2'(c) &&
                        !(src_kind_ff[c] == 2'd3 ||
                          (block_ff[c/2] && count_ff[c] != 16'h0001))) begin
                    pend_ff[c] <= 1'b0;
                end
            end
        end
    end

    // fixed priority, lowest index wins
    always_comb begin
        win = 2'd0;
        win_ok = 1'b0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (pend_ff[c] && !(full_mode_ff[c/2] && c[0])) begin
                win = 2'(c);
                win_ok = 1'b1;
            end
        end
    end

    // flag clear only by the top channel using that source
    always_comb begin
        int_flag_clr_o = '0;
        if (state_ff == ST_DEAD && src_kind_ff[cur_ff] == 2'd1) begin
            int_flag_clr_o[src_int_ff[cur_ff]] = 1'b1;
        end
        for (int c = 0; c < NCH; c++) begin
            if (state_ff == ST_DEAD && c < cur_ff &&
                    src_kind_ff[c] == 2'd1 &&
                    src_int_ff[c] == src_int_ff[cur_ff]) begin
                int_flag_clr_o = '0;
            end
        end
    end

    // interrupts routed to dma not cpu while selected and enabled
    always_comb begin
        int_to_cpu_o = int_flag_i;
        for (int c = 0; c < NCH; c++) begin
            if (src_kind_ff[c] == 2'd1 && chan_en_ff[c]) begin
                int_to_cpu_o[src_int_ff[c]] = 1'b0;
            end
        end
    end

    // continue after a unit only for bursts/blocks with no better claim
    assign last_c = count_ff[cur_ff] == 16'h0001;
    always_comb begin
        yield_c = 1'b1;
        if ((burst_ff[cur_ff[1]] && src_kind_ff[cur_ff] == 2'd3) ||
                (block_ff[cur_ff[1]] && !last_c)) begin
            yield_c = !full_mode_ff[cur_ff[1]] || halt_c[cur_ff] ||
                      !external_bus_request_n_i || refresh_req_i ||
                      (win_ok && win < cur_ff);
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (win_ok) nxt_state = ST_BUSREQ;
            ST_BUSREQ: begin
                if (bus_grant_i && wait_ff == 3'd0) nxt_state = ST_DEAD;
            end
            ST_DEAD: nxt_state = ST_READ;
            ST_READ: if (bus_cycle_done_i) nxt_state = ST_WRITE;
            ST_WRITE: begin
                if (bus_cycle_done_i) begin
                    if (yield_c || last_c) begin
                        nxt_state = ST_REL;
                    end else begin
                        nxt_state = ST_READ;
                    end
                end
            end
            ST_REL: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // channel latched at grant; others wait until release
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            cur_ff <= 2'd0;
        end else if (state_ff == ST_BUSREQ && nxt_state == ST_DEAD) begin
            cur_ff <= win;
        end
    end

    // four-state minimum response
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            wait_ff <= 3'd0;
        end else if (state_ff == ST_IDLE && win_ok) begin
            wait_ff <= `START_DELAY - 3'd2;
        end else if (wait_ff != 3'd0) begin
            wait_ff <= wait_ff - 3'd1;
        end
    end

    // transfer end strobe during the final write
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            transfer_end_n_o <= 2'b11;
        end else begin
            transfer_end_n_o <= 2'b11;
            if (nxt_state == ST_WRITE && last_c &&
                    src_kind_ff[cur_ff] == 2'd2) begin
                transfer_end_n_o[cur_ff[1]] <= 1'b0;
            end
        end
    end

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            req_pin_force_in_o[p] = src_kind_ff[2*p+1] == 2'd2;
        end
    end
    assign transfer_end_oe_o = req_pin_force_in_o;

    // bus stays requested from request state through write
    assign bus_req_o = state_ff inside {ST_BUSREQ, ST_DEAD, ST_READ,
                                       ST_WRITE};
    assign bus_read_o = state_ff == ST_READ;
    assign bus_write_o = state_ff == ST_WRITE;
    assign active_chan_o = cur_ff;
    assign end_irq_o = ~chan_en_ff & end_ie_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= 32'h0000_0000;
        end else if (wb_req) begin
            case (widx)
                `ADR_CHAN_CTRL: rdat_ff <= {22'h0, master_en_ff,
                                            end_ie_ff, chan_en_ff};
                `ADR_STATUS: rdat_ff <= {16'h0, pend_ff, 2'b00, cur_ff,
                                         2'b00, state_ff};
                `ADR_COUNT0, `ADR_COUNT1, `ADR_COUNT2, `ADR_COUNT3:
                    rdat_ff <= {16'h0, count_ff[widx[1:0]]};
                default: rdat_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdat_ff;
endmodule

// ==== bench/dma_act_arb_assertions.sv ====
// port checks for the dma activation and arbitration block
`timescale 1ns/1ps
module dma_act_arb_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] int_flag_i,
    input wire logic [5:0] int_flag_clr_o,
    input wire logic [5:0] int_to_cpu_o,
    input wire logic [1:0] req_pin_force_in_o,
    input wire logic [1:0] transfer_end_n_o,
    input wire logic [1:0] transfer_end_oe_o,
    input wire logic external_bus_request_n_i,
    input wire logic refresh_req_i,
    input wire logic bus_req_o,
    input wire logic bus_grant_i,
    input wire logic bus_read_o,
    input wire logic bus_write_o,
    input wire logic bus_cycle_done_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_contested_end;
        bus_write_o && bus_cycle_done_i &&
            (!external_bus_request_n_i || refresh_req_i);
    endsequence
    // a read that does not follow a write opens a fresh bus tenure
    property p_dead_first;
        $rose(bus_read_o) && !$past(bus_write_o) |->
            $past(bus_grant_i, 2) && !$past(bus_write_o, 2);
    endproperty
    a_dead_first: assert property (p_dead_first)
        else $error("no dead state");
    property p_read_to_write;
        $fell(bus_read_o) |-> bus_write_o;
    endproperty
    a_read_to_write: assert property (p_read_to_write)
        else $error("read end");
    // the bus has been asked for at least four cycles before a fresh read
    property p_min_start;
        $rose(bus_read_o) && !$past(bus_write_o) |->
            $past(bus_req_o, 3) && $past(bus_req_o, 4);
    endproperty
    a_min_start: assert property (p_min_start)
        else $error("start too soon");
    // the end strobe may stand through the whole last write, never beyond
    property p_end_write(te);
        !te |-> bus_write_o;
    endproperty
    a_end_write0: assert property (p_end_write(transfer_end_n_o[0]))
        else $error("end 0");
    a_end_write1: assert property (p_end_write(transfer_end_n_o[1]))
        else $error("end 1");
    property p_end_rel(te);
        $fell(bus_write_o) |-> te;
    endproperty
    a_end_rel0: assert property (p_end_rel(transfer_end_n_o[0]))
        else $error("end 0 after write");
    a_end_rel1: assert property (p_end_rel(transfer_end_n_o[1]))
        else $error("end 1 after write");
    property p_no_leak;
        (int_to_cpu_o & ~int_flag_i) == 6'h0;
    endproperty
    a_no_leak: assert property (p_no_leak)
        else $error("cpu irq leak");
    property p_flag_clr;
        |int_flag_clr_o |-> bus_grant_i && !bus_read_o && !bus_write_o &&
            (int_flag_clr_o & int_to_cpu_o) == 6'h0;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("flag clear");
    property p_pin_dir;
        transfer_end_oe_o == req_pin_force_in_o;
    endproperty
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin direction");
    property p_yield;
        s_contested_end |-> ##[1:2] !bus_req_o;
    endproperty
    a_yield: assert property (p_yield)
        else $error("bus not yielded");
endmodule

// ==== bench/bus_partner.sv ====
// system bus arbiter and bus cycle timer on the far side of the dma block
`timescale 1ns/1ps
module bus_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_req_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [1:0] wait_i,
    output logic grant_o,
    output logic done_o
);
    logic [1:0] cnt_ff;
    always_ff @(posedge clk_i) begin
        grant_o <= !rst_i && bus_req_i;
    end
    // each phase ends wait_i cycles late, as a slow area would stretch it
    always_ff @(posedge clk_i) begin
        if (rst_i || !(rd_i || wr_i) || done_o) begin
            cnt_ff <= 2'h0;
            done_o <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            done_o <= cnt_ff == wait_i;
        end
    end
endmodule

// ==== bench/tb_dma_act_arb.sv ====
// self-checking bench for the dma activation and arbitration block
`timescale 1ns/1ps
module tb_dma_act_arb import dma_act_pkg::*;;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, nmi_i;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rdata;
    logic [3:0] wb_sel_i, end_irq_o;
    logic [5:0] int_flag_i, int_flag_clr_o, int_to_cpu_o;
    logic [1:0] ext_transfer_request_n_i, req_pin_force_in_o, wait_cyc;
    logic [1:0] transfer_end_n_o, transfer_end_oe_o, active_chan_o, ord[$];
    logic standby_i, external_bus_request_n_i, refresh_req_i, req_q;
    logic bus_req_o, bus_grant_i, bus_read_o, bus_write_o, bus_cycle_done_i;
    int bad_count, n_checks, units[4], rises, tends, contest;
    dma_act_arb #(.NCH(4)) i_dma_act_arb (.clk_i, .rst_i, .wb_adr_i,
        .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
        .wb_ack_o, .int_flag_i, .int_flag_clr_o, .int_to_cpu_o,
        .ext_transfer_request_n_i, .req_pin_force_in_o, .transfer_end_n_o,
        .transfer_end_oe_o, .nmi_i, .standby_i, .external_bus_request_n_i,
        .refresh_req_i, .bus_req_o, .bus_grant_i, .bus_read_o, .bus_write_o,
        .bus_cycle_done_i, .active_chan_o, .end_irq_o);
    bus_partner i_bus_partner (.clk_i, .rst_i, .bus_req_i(bus_req_o),
        .rd_i(bus_read_o), .wr_i(bus_write_o), .wait_i(wait_cyc),
        .grant_o(bus_grant_i), .done_o(bus_cycle_done_i));
    // counts units, bus tenures and end pulses; acts as interrupt source
    always @(posedge clk_i) begin
        if (bus_req_o && !req_q)
            rises++;
        req_q <= bus_req_o;
        if (bus_write_o && bus_cycle_done_i) begin
            units[active_chan_o]++;
            ord.push_back(active_chan_o);
        end
        // one count per unit whose write ends with end strobe 0 low
        if (!transfer_end_n_o[0] && bus_write_o && bus_cycle_done_i)
            tends++;
        if (|int_flag_clr_o)
            int_flag_i <= int_flag_i & ~int_flag_clr_o;
        refresh_req_i <= contest == 1 && bus_write_o && units[0] == 0;
        external_bus_request_n_i <= !(contest == 2 && bus_write_o &&
            units[0] == 0);
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic [3:0] idx, input logic [31:0] d,
            input logic we, input logic [3:0] sel);
        int n;
        n = 0;
        wb_adr_i <= {26'h0, idx, 2'h0};
        wb_dat_i <= d;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (wb_ack_o !== 1'b1)
            bad_count++;
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        bus(idx, d, 1'b1, 4'hf);
    endtask
    task automatic rd(input logic [3:0] idx);
        bus(idx, 32'h0, 1'b0, 4'hf);
    endtask
    // waits for 24 quiet clock cycles so a late re-request is not missed
    task automatic settle();
        int n, q;
        n = 0;
        q = 0;
        while (q < 24 && n < 3000) begin
            @(posedge clk_i);
            n++;
            q = (bus_req_o || bus_read_o || bus_write_o) ? 0 : q + 1;
        end
    endtask
    task automatic wait_rd(input int ch, input int u);
        int n;
        n = 0;
        while (!(bus_read_o === 1'b1 && units[ch] == u) && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic pulse(input logic [1:0] p);
        ext_transfer_request_n_i <= p;
        repeat (3) @(posedge clk_i);
        ext_transfer_request_n_i <= 2'b11;
        settle();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        bad_count++;
        test_done();
    end
    initial begin
        {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, nmi_i, standby_i} = 6'h20;
        {wb_adr_i, wb_dat_i, wb_sel_i, int_flag_i} = 74'h0;
        {refresh_req_i, external_bus_request_n_i, req_q} = 3'b010;
        ext_transfer_request_n_i = 2'b11;
        wait_cyc = 2'h0;
        contest = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(4'h3);
        chk("state", rdata & 32'h3f, 32'(ST_IDLE));
        rd(4'h8);
        chk("unmapped", rdata, 32'h0);
        bus(4'h0, 32'hf0, 1'b1, 4'he);
        rd(4'h0);
        chk("sel0 low", rdata, 32'h0);
        wr(4'h0, 32'hf0);
        chk("end irq", 32'(end_irq_o), 32'hf);
        standby_i <= 1'b1;
        @(posedge clk_i);
        standby_i <= 1'b0;
        rd(4'h0);
        chk("standby", rdata, 32'h0);
        $display("register test done");
        for (int v = 0; v < 4; v++) begin
            contest = v > 1 ? v - 1 : 0;
            rises = 0;
            units = '{0, 0, 0, 0};
            wr(4'h1, v > 0 ? 32'h11 : 32'h1);
            wr(4'h2, 32'h3);
            wr(4'h4, 32'h3);
            wr(4'h0, 32'h111);
            settle();
            chk("units", units[0], 32'h3);
            chk("tenures", rises, v == 0 ? 3 : v == 1 ? 1 : 2);
            rd(4'h0);
            chk("done ctrl", rdata, 32'h110);
            chk("end irq", 32'(end_irq_o), 32'h1);
        end
        contest = 0;
        units = '{0, 0, 0, 0};
        wr(4'h1, 32'h1);
        wr(4'h4, 32'h4);
        wr(4'h0, 32'h111);
        wait_rd(0, 1);
        nmi_i <= 1'b1;
        @(posedge clk_i);
        nmi_i <= 1'b0;
        settle();
        chk("nmi units", units[0], 32'h2);
        rd(4'h0);
        chk("nmi ctrl", rdata, 32'h011);
        wr(4'h0, 32'h111);
        settle();
        chk("resumed", units[0], 32'h4);
        $display("auto request test done");
        tends = 0;
        wr(4'h1, 32'h0);
        wr(4'h2, 32'h200);
        wr(4'h5, 32'h2);
        wr(4'h0, 32'h22);
        chk("pin dir", 32'(req_pin_force_in_o & transfer_end_oe_o),
            32'h1);
        pulse(2'b10);
        chk("edge one", units[1] * 16 + tends, 32'h10);
        pulse(2'b10);
        chk("edge two", units[1] * 16 + tends, 32'h21);
        wait_cyc <= 2'h2;
        wr(4'h1, 32'h800);
        wr(4'h2, 32'h0200_0000);
        wr(4'h7, 32'h8);
        wr(4'h0, 32'h8);
        pulse(2'b01);
        chk("latched", units[3], 32'h1);
        ext_transfer_request_n_i <= 2'b01;
        wait_rd(3, 2);
        ext_transfer_request_n_i <= 2'b11;
        settle();
        chk("level stop", units[3], 32'h3);
        wait_cyc <= 2'h0;
        $display("external request test done");
        ord.delete();
        wr(4'h1, 32'h0);
        wr(4'h2, 32'h0009_0009);
        wr(4'h4, 32'h1);
        wr(4'h6, 32'h1);
        wr(4'h0, 32'h5);
        int_flag_i <= 6'h04;
        repeat (2) @(posedge clk_i);
        chk("to cpu", 32'(int_to_cpu_o), 32'h0);
        settle();
        chk("order", {28'h0, ord[0], ord[1]}, 32'h2);
        chk("flag", 32'(int_flag_i), 32'h0);
        int_flag_i <= 6'h04;
        repeat (2) @(posedge clk_i);
        chk("cpu again", 32'(int_to_cpu_o), 32'h4);
        $display("interrupt test done");
        test_done();
    end
endmodule
bind dma_act_arb dma_act_arb_chk i_dma_act_arb_chk (.clk_i, .rst_i,
    .int_flag_i, .int_flag_clr_o, .int_to_cpu_o, .req_pin_force_in_o,
    .transfer_end_n_o, .transfer_end_oe_o, .external_bus_request_n_i,
    .refresh_req_i, .bus_req_o, .bus_grant_i, .bus_read_o, .bus_write_o,
    .bus_cycle_done_i);
